//--- logic/uart_aux_pkg.sv
/*
  Constants, carrier types and state record for the auxiliary UART channel
  logic. Assumes a 100 MHz ref_clk and a 16x baud tick from the base UART.
*/
package uart_aux_pkg;

  // ----------------------------------------------------------------
  // Register word indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_EFR    = 4'h0;
  localparam logic [3:0] IDX_IER    = 4'h1;
  localparam logic [3:0] IDX_ISR    = 4'h2;
  localparam logic [3:0] IDX_LCR    = 4'h3;
  localparam logic [3:0] IDX_MCR    = 4'h4;
  localparam logic [3:0] IDX_MSR    = 4'h5;
  localparam logic [3:0] IDX_PAUSE1 = 4'h6;
  localparam logic [3:0] IDX_PAUSE2 = 4'h7;
  localparam logic [3:0] IDX_RESUM1 = 4'h8;
  localparam logic [3:0] IDX_RESUM2 = 4'h9;
  localparam logic [3:0] IDX_STAT   = 4'ha;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EFR_SWRX    = 0;
  localparam int EFR_DOUBLE  = 1;
  localparam int EFR_AUTOTX  = 2;
  localparam int EFR_ENH     = 4;
  localparam int EFR_SPECIAL = 5;
  localparam int IER_SLEEP   = 4;
  localparam int IER_PAUSE   = 5;
  localparam int ISR_FLAG    = 4;
  localparam int MCR_DTR     = 0;
  localparam int MCR_RTS     = 1;
  localparam int MCR_LOOP    = 4;
  localparam int MCR_IR      = 6;
  localparam int LCR_TRIG    = 4;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RST        = 8'h00;
  localparam logic [7:0] ENH_WR_MASK    = 8'hf0;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [4:0] IR_STRETCH     = 5'h10;
  localparam int         TICKS_PER_BIT  = 16;
  localparam int         FRAME_EXTRA    = 7;
  localparam int         CHARS_DELAY    = 2;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } char_t;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } modem_in_t;

  typedef enum logic [2:0] {
    AF_IDLE, AF_WAIT, AF_SEND_P, AF_HELD, AF_SEND_R
  } afc_t;

  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic [7:0]  enhanced_feature_reg, interrupt_enable_reg, line_control_reg, modem_control_reg;
    logic [7:0]  pch1, pch2, rch1, rch2;
    logic        flag;
    logic [3:0]  delta;
    logic [4:0]  s1, s2, s3;
    logic        held_v;
    logic [7:0]  held;
    logic        pend_v;
    logic [7:0]  pend;
    char_t       rxo;
    logic        paused;
    logic        tx_hold;
    afc_t        afc;
    logic [9:0]  cnt;
    logic        idx;
    char_t       ftx;
    logic        sleep;
    logic        tx_pin;
    logic        rx_ser;
    logic [4:0]  irc;
    logic        irq;
    logic        rts_n;
    logic        dtr_n;
  } state_t;

endpackage

//--- logic/uart_aux.sv
/*
  Auxiliary logic of one UART channel: software flow control, special
  character detect, infrared coding, sleep control and internal loopback,
  with an Avalon-MM register slave. Assumes the base UART supplies received
  characters, a 16x tick, its serial output with bit phase, and the FIFO
  fill level, all on ref_clk.
*/
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
// Contract
// - With software flow on, compare each received character or pair.
// - On pause match, halt transmitter after current character finishes.
// - Pause match sets flag; interrupt out when pause enable bit 5 set.
// - While paused, resume match restarts transmit and clears status bit 4.
// - Reset zeroes all four pause and resume character registers.
// - Matched flow characters are dropped, not passed to receive FIFO.
// - Auto mode sends pause characters two character times after trigger.
// - Resume characters sent when fill drops to one step under trigger.
// - Special detect passes second pause character and sets status bit 4.
// - Comparisons use only configured word length low bits.
// - Infrared encoder pulses high 3/16 bit for each zero bit.
// - Control bit 6 enables infrared; transmit output idles low.
// - Infrared decoder takes low as idle receive level.
// - Sleep only when idle, enabled, no modem deltas, receive high. The code skips the receive-high check while control bit 6 (infrared) is set.
// - In sleep the oscillator output is stopped.
// - Wake on receive start edge, transmit write, or modem change.
// - Return to sleep once interrupts cleared; host reads modem status.
// - Sleep stays armed until software clears enable bit 4.
// - Control bit 4 loops transmit serial output to receive input.
// - In loopback transmit pin marks, modem outputs off, inputs ignored.
// - Enhanced enable bits writable only while feature bit 4 set.
module uart_aux
  import uart_aux_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Avalon-MM slave
  input  wire logic [5:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  // Base UART side
  input  uart_aux_pkg::char_t    rx_char_in,
  output uart_aux_pkg::char_t    rx_char_out,
  input  wire logic [6:0]        rx_fill,
  input  wire logic              baud_tick,
  input  wire logic              tx_serial_in,
  input  wire logic [3:0]        tx_bit_phase,
  input  wire logic              tx_shift_busy,
  input  wire logic              thr_write,
  output logic                   tx_hold,
  output uart_aux_pkg::char_t    flow_tx,
  input  wire logic              flow_tx_ready,
  output logic                   rx_serial_out,
  // Chip level
  input  wire logic              others_idle,
  output logic                   osc_enable,
  output logic                   irq,
  // Pins
  input  wire logic              rx_pin,
  input  uart_aux_pkg::modem_in_t modem_in,
  output logic                   tx_pin,
  output logic                   rts_n,
  output logic                   dtr_n
);
  import uart_aux_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic char_eq(input logic [7:0] a,
                                   input logic [7:0] b,
                                   input logic [1:0] wl);
    logic [7:0] m;
    m = 8'hff >> (2'd3 - wl);
    char_eq = ((a ^ b) & m) == 8'h00;
  endfunction

  function automatic logic [6:0] trig_hi(input logic [1:0] sel);
    case (sel)
      2'd0:    trig_hi = 7'h08;
      2'd1:    trig_hi = 7'h10;
      2'd2:    trig_hi = 7'h38;
      default: trig_hi = 7'h3c;
    endcase
  endfunction

  function automatic logic [6:0] trig_lo(input logic [1:0] sel);
    case (sel)
      2'd0:    trig_lo = 7'h00;
      2'd1:    trig_lo = 7'h08;
      2'd2:    trig_lo = 7'h10;
      default: trig_lo = 7'h38;
    endcase
  endfunction

  state_t c, n;

  logic [1:0] wl;
  logic [1:0] tsel;
  logic [9:0] delay_ticks;
  logic       take;
  logic       rx_lvl;
  logic       rx_fall;
  logic [3:0] m_lvl;
  logic [3:0] m_chg;
  logic       sleep_ok;
  logic       wake;
  logic       flow_on;
  logic       dbl;
  logic       is_p1, is_p2, is_r1, is_r2, is_sp;
  logic [7:0] ch;

  assign wl          = c.line_control_reg[1:0];
  assign tsel        = c.line_control_reg[LCR_TRIG+1:LCR_TRIG];
  assign delay_ticks = 10'(CHARS_DELAY * TICKS_PER_BIT * FRAME_EXTRA)
                     + 10'(CHARS_DELAY * TICKS_PER_BIT) * {8'h00, wl};
  assign take        = (read | write) & ~c.waitreq;
  assign rx_lvl      = c.s2[4];
  assign rx_fall     = ~c.s2[4] & c.s3[4];
  assign m_lvl       = c.s2[3:0];
  assign m_chg       = c.s2[3:0] ^ c.s3[3:0];
  assign flow_on     = c.enhanced_feature_reg[EFR_SWRX];
  assign dbl         = c.enhanced_feature_reg[EFR_DOUBLE];
  assign ch          = rx_char_in.data;
  assign is_p1       = char_eq(ch, c.pch1, wl);
  assign is_p2       = char_eq(ch, c.pch2, wl);
  assign is_r1       = char_eq(ch, c.rch1, wl);
  assign is_r2       = char_eq(ch, c.rch2, wl);
  assign is_sp       = c.enhanced_feature_reg[EFR_SPECIAL] & is_p2;

  always_comb begin
    n = c;
    n.s1 = {rx_pin, modem_in};
    n.s2 = c.s1;
    n.s3 = c.s2;
    n.rxo.valid = 1'b0;
    n.rxo.data  = c.rxo.data;

    // ----------------------------------------------------------------
    // Register slave: one wait cycle, then answer
    // ----------------------------------------------------------------
    n.waitreq = 1'b1;
    if ((read | write) & c.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata = 32'h0000_0000;
      case (address[5:2])
        IDX_EFR:    n.rdata[7:0] = c.enhanced_feature_reg;
        IDX_IER:    n.rdata[7:0] = c.interrupt_enable_reg;
        IDX_ISR:    n.rdata[ISR_FLAG] = c.flag;
        IDX_LCR:    n.rdata[7:0] = c.line_control_reg;
        IDX_MCR:    n.rdata[7:0] = c.modem_control_reg;
        IDX_MSR:    n.rdata[7:0] = {~m_lvl, c.delta};
        IDX_PAUSE1: n.rdata[7:0] = c.pch1;
        IDX_PAUSE2: n.rdata[7:0] = c.pch2;
        IDX_RESUM1: n.rdata[7:0] = c.rch1;
        IDX_RESUM2: n.rdata[7:0] = c.rch2;
        IDX_STAT:   n.rdata[3:0] = {c.sleep, c.tx_hold, c.paused, c.idx};
        default:    n.rdata = 32'h0000_0000;
      endcase
    end
    if (take & write) begin
      case (address[5:2])
        IDX_EFR:    n.enhanced_feature_reg = writedata[7:0];
        IDX_IER:    n.interrupt_enable_reg = c.enhanced_feature_reg[EFR_ENH] ? writedata[7:0]
                          : (c.interrupt_enable_reg & ENH_WR_MASK)
                          | (writedata[7:0] & ~ENH_WR_MASK);
        IDX_LCR:    n.line_control_reg = writedata[7:0];
        IDX_MCR:    n.modem_control_reg = writedata[7:0];
        IDX_PAUSE1: n.pch1 = writedata[7:0];
        IDX_PAUSE2: n.pch2 = writedata[7:0];
        IDX_RESUM1: n.rch1 = writedata[7:0];
        IDX_RESUM2: n.rch2 = writedata[7:0];
        default:    n.rdata = c.rdata;
      endcase
    end
    // Reading clears; a new event in the same cycle wins below
    if (take & read & (address[5:2] == IDX_MSR)) n.delta = 4'h0;
    if (take & read & (address[5:2] == IDX_ISR)) n.flag = 1'b0;

    // ----------------------------------------------------------------
    // Modem inputs
    // ----------------------------------------------------------------
    // inputs ignored
    if (!c.modem_control_reg[MCR_LOOP]) n.delta = n.delta | m_chg;

    // ----------------------------------------------------------------
    // Receive character filter
    // ----------------------------------------------------------------
    // A deferred character goes out one cycle after its partner
    if (c.pend_v) begin
      n.rxo.valid = 1'b1;
      n.rxo.data  = c.pend;
      n.pend_v    = 1'b0;
    end
    if (rx_char_in.valid) begin
      if (is_sp) begin
        n.rxo.valid = 1'b1;
        n.rxo.data  = ch;
        n.flag      = 1'b1;
      end else if (!flow_on) begin
        n.rxo.valid = 1'b1;
        n.rxo.data  = ch;
      end else if (!dbl) begin
        if (is_p1) begin
          n.paused = 1'b1;
          n.flag   = 1'b1;
        end else if (is_r1 & c.paused) begin
          n.paused = 1'b0;
          n.flag   = 1'b0;
        end else begin
          n.rxo.valid = 1'b1;
          n.rxo.data  = ch;
        end
      end else begin
        if (c.held_v & char_eq(c.held, c.pch1, wl) & is_p2) begin
          n.held_v = 1'b0;
          n.paused = 1'b1;
          n.flag   = 1'b1;
        end else if (c.held_v & char_eq(c.held, c.rch1, wl) & is_r2
                     & c.paused) begin
          n.held_v = 1'b0;
          n.paused = 1'b0;
          n.flag   = 1'b0;
        end else begin
          if (c.held_v) begin
            n.rxo.valid = 1'b1;
            n.rxo.data  = c.held;
          end
          n.held_v = is_p1 | (is_r1 & c.paused);
          n.held   = ch;
          if (!n.held_v & c.held_v) begin
            n.pend_v = 1'b1;
            n.pend   = ch;
          end else if (!n.held_v) begin
            n.rxo.valid = 1'b1;
            n.rxo.data  = ch;
          end
        end
      end
    end
    if (!flow_on) n.paused = 1'b0;

    n.tx_hold = n.paused & (c.tx_hold | ~tx_shift_busy);

    // ----------------------------------------------------------------
    // Automatic pause and resume transmission
    // ----------------------------------------------------------------
    case (c.afc)
      AF_IDLE: begin
        n.cnt = 10'h000;
        n.idx = 1'b0;
        if (c.enhanced_feature_reg[EFR_AUTOTX] & (rx_fill >= trig_hi(tsel)))
          n.afc = AF_WAIT;
      end
      AF_WAIT: begin
        if (baud_tick) n.cnt = c.cnt + 10'h001;
        if (c.cnt >= delay_ticks - 10'h001) n.afc = AF_SEND_P;
      end
      AF_SEND_P, AF_SEND_R: begin
        if (!c.ftx.valid) begin
          n.ftx.valid = 1'b1;
          n.ftx.data  = (c.afc == AF_SEND_P)
                      ? (c.idx ? c.pch2 : c.pch1)
                      : (c.idx ? c.rch2 : c.rch1);
        end else if (flow_tx_ready) begin
          n.ftx.valid = 1'b0;
          if (dbl & ~c.idx) begin
            n.idx = 1'b1;
          end else begin
            n.idx = 1'b0;
            n.afc = (c.afc == AF_SEND_P) ? AF_HELD : AF_IDLE;
          end
        end
      end
      AF_HELD: begin
        if (rx_fill <= trig_lo(tsel)) n.afc = AF_SEND_R;
      end
      default: n.afc = AF_IDLE;
    endcase

    // ----------------------------------------------------------------
    // Infrared decode and serial routing
    // ----------------------------------------------------------------
    // low idles; each pulse is a zero bit for one bit time
    if (rx_lvl & ~c.s3[4]) n.irc = IR_STRETCH;
    else if (baud_tick & (c.irc != 5'h00)) n.irc = c.irc - 5'h01;

    if (c.modem_control_reg[MCR_LOOP]) begin
      n.rx_ser = tx_serial_in;
      n.tx_pin = 1'b1;
      n.rts_n  = 1'b1;
      n.dtr_n  = 1'b1;
    end else begin
      n.rts_n = ~c.modem_control_reg[MCR_RTS];
      n.dtr_n = ~c.modem_control_reg[MCR_DTR];
      if (c.modem_control_reg[MCR_IR]) begin
        n.rx_ser = (c.irc == 5'h00);
        n.tx_pin = ~tx_serial_in & (tx_bit_phase < IR_PULSE_TICKS);
      end else begin
        n.rx_ser = rx_lvl;
        n.tx_pin = tx_serial_in;
      end
    end

    // ----------------------------------------------------------------
    // Interrupt and sleep
    // ----------------------------------------------------------------
    // interrupt gate
    n.irq = n.flag & c.interrupt_enable_reg[IER_PAUSE];
    sleep_ok = others_idle & c.interrupt_enable_reg[IER_SLEEP] & ~c.irq & ~n.irq
             & (c.delta == 4'h0) & (rx_lvl | c.modem_control_reg[MCR_IR]);
    wake = rx_fall | thr_write | ((m_chg != 4'h0) & ~c.modem_control_reg[MCR_LOOP]);
    if (c.sleep) begin
      if (wake | ~c.interrupt_enable_reg[IER_SLEEP]) n.sleep = 1'b0;
    end else if (sleep_ok & ~wake) begin
      n.sleep = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      c <= '0;
      c.waitreq <= 1'b1;
      c.pch1 <= REG_RST;
      c.pch2 <= REG_RST;
      c.rch1 <= REG_RST;
      c.rch2 <= REG_RST;
      c.s1 <= 5'h1f;
      c.s2 <= 5'h1f;
      c.s3 <= 5'h1f;
      c.rx_ser <= 1'b1;
      c.irc <= 5'h00;
      c.rts_n <= 1'b1;
      c.dtr_n <= 1'b1;
      c.afc <= AF_IDLE;
    end else begin
      c <= n;
    end
  end

  assign readdata      = c.rdata;
  assign waitrequest   = c.waitreq;
  assign rx_char_out   = c.rxo;
  assign tx_hold       = c.tx_hold;
  assign flow_tx       = c.ftx;
  assign rx_serial_out = c.rx_ser;
  assign osc_enable    = ~c.sleep;
  assign irq           = c.irq;
  assign tx_pin        = c.tx_pin;
  assign rts_n         = c.rts_n;
  assign dtr_n         = c.dtr_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_pause_drop: assert property (
    rx_char_in.valid & flow_on & ~dbl & ~is_sp & is_p1 & ~c.pend_v
    |=> ~rx_char_out.valid & c.paused)
    else $error("pause character passed or not acted on");
  a_hold_waits: assert property (
    c.paused & ~c.tx_hold & tx_shift_busy
    |=> ~tx_hold)
    else $error("transmit held before current character ended");
  a_flag_irq: assert property (
    rx_char_in.valid & flow_on & ~dbl & is_p1 & c.interrupt_enable_reg[IER_PAUSE]
    |=> c.flag ##1 irq)
    else $error("pause match did not raise interrupt");
  a_resume_send: assert property (
    (c.afc == AF_HELD) & (rx_fill <= trig_lo(tsel))
    |=> (c.afc == AF_SEND_R) ##1 flow_tx.valid)
    else $error("resume characters not started");
  a_pause_delay: assert property (
    (c.afc == AF_IDLE) & c.enhanced_feature_reg[EFR_AUTOTX] & (rx_fill >= trig_hi(tsel))
    |=> (c.afc == AF_WAIT) & ~flow_tx.valid)
    else $error("pause sent without delay");
  a_loop_pins: assert property (
    c.modem_control_reg[MCR_LOOP] |=> tx_pin & rts_n & dtr_n)
    else $error("loopback pins not parked");
  a_ir_idle: assert property (
    c.modem_control_reg[MCR_IR] & ~c.modem_control_reg[MCR_LOOP] & tx_serial_in |=> ~tx_pin)
    else $error("infrared output not idle low");
  a_wake_tx: assert property (
    c.sleep & thr_write |=> ~c.sleep & osc_enable)
    else $error("no wake on transmit write");
  a_bus_answer: assert property (
    (read | write) & waitrequest |=> ~waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");

endmodule // uart_aux

//--- verif/remote_end.sv
/*
  Far-end model: a remote UART or modem on the serial line and modem pins.
  Assumes the bench calls its tasks just after a rising ref_clk edge.
*/
module remote_end
  import uart_aux_pkg::*;
(
  // Clock
  input  wire logic               ref_clk,
  // Serial line
  input  wire logic               tx_pin,
  output logic                    rx_pin,
  output uart_aux_pkg::modem_in_t modem_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Line levels
  // ----------------------------------------------------------------
  // receive line kept marking
  initial begin
    rx_pin   = 1'b1;
    modem_in = 4'hf;
  end

  // A single level change, as a modem would show it
  task automatic flip_cts();
    modem_in.cts_n <= ~modem_in.cts_n;
  endtask

  // Light pulse on an infrared link: line idles low, high for a few cycles
  task automatic ir_flash();
    rx_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rx_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rx_pin <= 1'b0;
  endtask
endmodule // remote_end

//--- verif/tb_top.sv
/*
  Self-checking bench for the auxiliary UART channel logic.
  Assumes the design package and remote_end model are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_aux_pkg::*;

  logic ref_clk, reset, read, write, baud_tick, tx_serial_in, tx_shift_busy;
  logic thr_write, flow_tx_ready, others_idle, tx_hold, rx_serial_out;
  logic osc_enable, irq, rx_pin, tx_pin, rts_n, dtr_n, waitrequest;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, d;
  logic [3:0]  tx_bit_phase;
  logic [6:0]  rx_fill;
  char_t       rx_char_in, rx_char_out, flow_tx;
  modem_in_t   modem_in;
  int          mismatches, tests_run, cyc, k;

  uart_aux dut (.ref_clk(ref_clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rx_char_in(rx_char_in),
    .rx_char_out(rx_char_out), .rx_fill(rx_fill), .baud_tick(baud_tick),
    .tx_serial_in(tx_serial_in), .tx_bit_phase(tx_bit_phase),
    .tx_shift_busy(tx_shift_busy), .thr_write(thr_write),
    .tx_hold(tx_hold), .flow_tx(flow_tx), .flow_tx_ready(flow_tx_ready),
    .rx_serial_out(rx_serial_out), .others_idle(others_idle),
    .osc_enable(osc_enable), .irq(irq), .rx_pin(rx_pin),
    .modem_in(modem_in), .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n));

  remote_end rem (.ref_clk(ref_clk), .tx_pin(tx_pin), .rx_pin(rx_pin),
    .modem_in(modem_in));

  // ----------------------------------------------------------------
  // Clock, bit phase and timeout
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    tx_bit_phase <= tx_bit_phase + 4'h1;
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Avalon access held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] i, input logic [7:0] v);
    address   <= {i, 2'b00};
    writedata <= {24'h0, v};
    write     <= w;
    read      <= ~w;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    d = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [3:0] i, input logic [31:0] m, e);
    acc(1'b0, i, 8'h00);
    chk(d & m, e);
  endtask

  // Characters kept at least three cycles apart
  task automatic rxc(input logic [7:0] b, input logic v);
    rx_char_in <= '{valid: 1'b1, data: b};
    @(posedge ref_clk);
    rx_char_in <= '0;
    @(posedge ref_clk);
    chk({31'h0, rx_char_out.valid}, {31'h0, v});
    if (v) chk({24'h0, rx_char_out.data}, {24'h0, b});
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic wait_osc(input logic lvl);
    k = 0;
    while (osc_enable !== lvl && k < 60) begin
      @(posedge ref_clk);
      k++;
    end
    chk({31'h0, osc_enable}, {31'h0, lvl});
  endtask

  task automatic ir_count(input logic b, input int e);
    tx_serial_in <= b;
    repeat (20) @(posedge ref_clk);
    k = 0;
    repeat (16) begin
      @(posedge ref_clk);
      k += int'(tx_pin === 1'b1);
    end
    chk(k, e);
  endtask

  // Flow character wait; ready is high so it is taken at the next edge
  task automatic flow_wait(input logic [7:0] e, input int lo, hi,
                           input logic seen);
    k = 0;
    while (flow_tx.valid !== 1'b1 && k < hi) begin
      @(posedge ref_clk);
      k++;
    end
    chk({31'h0, flow_tx.valid}, {31'h0, seen});
    if (seen) chk({31'h0, k >= lo}, 32'h1);
    if (seen) chk({24'h0, flow_tx.data}, {24'h0, e});
    @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    rx_char_in = '0; rx_fill = '0; baud_tick = 1'b1; tx_serial_in = 1'b1;
    tx_bit_phase = '0; tx_shift_busy = 1'b0; thr_write = 1'b0;
    flow_tx_ready = 1'b1; others_idle = 1'b1;
    mismatches = 0; tests_run = 0; cyc = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int i = 6; i < 10; i++) rd_chk(i[3:0], '1, 0);
    rd_chk(4'hb, '1, 0);
    acc(1'b1, IDX_IER, 8'hf0);
    rd_chk(IDX_IER, '1, 0);
    acc(1'b1, IDX_EFR, 8'h10);
    others_idle <= 1'b0;
    acc(1'b1, IDX_IER, 8'h10);
    rd_chk(IDX_IER, '1, 32'h10);
    chk({31'h0, osc_enable}, 32'h1);
    others_idle <= 1'b1;
    wait_osc(1'b0);
    thr_write <= 1'b1;
    @(posedge ref_clk);
    thr_write <= 1'b0;
    wait_osc(1'b1);
    wait_osc(1'b0);
    rem.flip_cts();
    wait_osc(1'b1);
    repeat (10) @(posedge ref_clk);
    chk({31'h0, osc_enable}, 32'h1);
    acc(1'b0, IDX_MSR, 8'h00);
    wait_osc(1'b0);
    acc(1'b1, IDX_IER, 8'h00);
    wait_osc(1'b1);
    // Loopback: modem outputs drop even with their control bits set
    acc(1'b1, IDX_MCR, 8'h03);
    repeat (3) @(posedge ref_clk);
    chk({rts_n, dtr_n}, 0);
    acc(1'b1, IDX_MCR, 8'h13);
    tx_serial_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({tx_pin, rts_n, dtr_n, rx_serial_out}, 4'he);
    rem.flip_cts();
    repeat (6) @(posedge ref_clk);
    rd_chk(IDX_MSR, 32'hf, 0);
    acc(1'b1, IDX_MCR, 8'h40);
    ir_count(1'b1, 0);
    ir_count(1'b0, 3);
    // One rising pulse gives one zero bit of 16 ticks; low idle gives none
    rem.ir_flash();
    k = 0;
    repeat (24) begin
      @(posedge ref_clk);
      k += int'(rx_serial_out === 1'b0);
    end
    chk(k, 16);
    tx_serial_in <= 1'b1;
    acc(1'b1, IDX_MCR, 8'h00);
    // Software flow control with 8-bit then 5-bit words
    acc(1'b1, IDX_LCR, 8'h03);
    acc(1'b1, IDX_PAUSE1, 8'h13);
    acc(1'b1, IDX_RESUM1, 8'h11);
    acc(1'b1, IDX_IER, 8'h20);
    acc(1'b1, IDX_EFR, 8'h11);
    rxc(8'h41, 1'b1);
    tx_shift_busy <= 1'b1;
    rxc(8'h13, 1'b0);
    chk({31'h0, tx_hold}, 0);
    tx_shift_busy <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({tx_hold, irq}, 2'b11);
    rd_chk(IDX_ISR, 32'h10, 32'h10);
    rxc(8'h11, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, tx_hold}, 0);
    acc(1'b1, IDX_LCR, 8'h00);
    rxc(8'hf3, 1'b0);
    rxc(8'hf1, 1'b0);
    acc(1'b1, IDX_LCR, 8'h03);
    acc(1'b1, IDX_PAUSE2, 8'h5a);
    // Double-character pause then resume pair
    acc(1'b1, IDX_EFR, 8'h13);
    rxc(8'h13, 1'b0);
    rxc(8'h5a, 1'b0);
    chk({31'h0, tx_hold}, 32'h1);
    rxc(8'h11, 1'b0);
    rxc(8'h00, 1'b0);
    chk({31'h0, tx_hold}, 0);
    acc(1'b1, IDX_EFR, 8'h30);
    rxc(8'h5a, 1'b1);
    rd_chk(IDX_ISR, 32'h10, 32'h10);
    // Automatic pause and resume at each trigger selection
    acc(1'b1, IDX_EFR, 8'h14);
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, IDX_LCR, {2'b00, s[1:0], 4'h3});
      rx_fill <= (s == 0) ? 7'd8 : (s == 1) ? 7'd16 : (s == 2) ? 7'd56 : 7'd60;
      flow_wait(8'h13, 300, 2000, 1'b1);
      rx_fill <= (s == 0) ? 7'd1 : (s == 1) ? 7'd9 : (s == 2) ? 7'd17 : 7'd57;
      flow_wait(8'h11, 0, 40, 1'b0);
      rx_fill <= (s == 0) ? 7'd0 : (s == 1) ? 7'd8 : (s == 2) ? 7'd16 : 7'd56;
      flow_wait(8'h11, 0, 40, 1'b1);
    end
    results();
  end
endmodule // tb_top
